//--- hw/bcd_map.vh
// constants for the brushless commutation decoder
`ifndef BCD_MAP_VH
`define BCD_MAP_VH
// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define BCD_CLK_MHZ 100
`define BCD_SPEED_PULSE_NS 140000
`define BCD_SPEED_PULSE_CYC ((`BCD_SPEED_PULSE_NS * `BCD_CLK_MHZ + 999) / 1000)
// -----------------------------------------------------------------------------
// phase one-hot positions {c,b,a}
// -----------------------------------------------------------------------------
`define BCD_PH_NONE 3'h0
`define BCD_PH_A 3'h1
`define BCD_PH_B 3'h2
`define BCD_PH_C 3'h4
`define BCD_LOW_RST 3'h0
`define BCD_HIGH_N_RST 3'h7
`endif

//--- hw/bcd_sync.v
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module bcd_sync #(
	parameter W = 4
) (
	// clock
	input wire clk,
	input wire rst,
	input wire ce,
	// data
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	always @(posedge clk) begin
		if (rst) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
		end else if (ce) begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end
	assign q = s2_q;
endmodule // bcd_sync

//--- hw/bcd_decoder.v
// commutation decoder top: position latch, speed pulse, drive decode
`timescale 1ns/1ps
`include "bcd_map.vh"
module bcd_decoder #(
	parameter PULSE_CYC = `BCD_SPEED_PULSE_CYC
) (
	// clock and reset
	input wire clk,
	input wire rst,
	input wire ce,
	// rotor position sensors
	input wire rotor_position_a,
	input wire rotor_position_b,
	input wire rotor_position_c,
	// control
	input wire direction,
	input wire speed_fast,
	input wire four_quadrant,
	input wire brake,
	input wire pwm_on,
	// speed pulse
	output reg speed_pulse,
	// drivers, phase order {c,b,a}
	output reg [2:0] low_side,
	output reg [2:0] high_side_n
);
	// -------------------------------------------------------------------------
	// input synchronisation
	// -------------------------------------------------------------------------
	wire [3:0] sync_w;
	bcd_sync #(.W(4)) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d({direction, rotor_position_a, rotor_position_b, rotor_position_c}),
		.q(sync_w)
	);
	wire dir_s = sync_w[3];
	wire [2:0] pos_s = sync_w[2:0];
	// -------------------------------------------------------------------------
	// decode: code is {a,b,c}; returns {low[2:0], high[2:0]} one-hot, both zero for codes 0 and 7
	// -------------------------------------------------------------------------
	function [5:0] bcd_decode;
		input fwd;
		input [2:0] code;
		begin
			bcd_decode = {`BCD_PH_NONE, `BCD_PH_NONE};
			if (fwd) begin
				case (code)
					3'h1: bcd_decode = {`BCD_PH_B, `BCD_PH_A};
					3'h3: bcd_decode = {`BCD_PH_C, `BCD_PH_A};
					3'h2: bcd_decode = {`BCD_PH_C, `BCD_PH_B};
					3'h6: bcd_decode = {`BCD_PH_A, `BCD_PH_B};
					3'h4: bcd_decode = {`BCD_PH_A, `BCD_PH_C};
					3'h5: bcd_decode = {`BCD_PH_B, `BCD_PH_C};
					default: bcd_decode = {`BCD_PH_NONE, `BCD_PH_NONE};
				endcase
			end else begin
				case (code)
					3'h5: bcd_decode = {`BCD_PH_C, `BCD_PH_B};
					3'h4: bcd_decode = {`BCD_PH_C, `BCD_PH_A};
					3'h6: bcd_decode = {`BCD_PH_B, `BCD_PH_A};
					3'h2: bcd_decode = {`BCD_PH_B, `BCD_PH_C};
					3'h3: bcd_decode = {`BCD_PH_A, `BCD_PH_C};
					3'h1: bcd_decode = {`BCD_PH_A, `BCD_PH_B};
					default: bcd_decode = {`BCD_PH_NONE, `BCD_PH_NONE};
				endcase
			end
		end
	endfunction
	// -------------------------------------------------------------------------
	// position latch, direction latch and speed pulse
	// -------------------------------------------------------------------------
	reg [2:0] pos_q;
	reg dir_q;
	reg [31:0] cnt_q;
	wire pos_change = (pos_s != pos_q);
	always @(posedge clk) begin
		if (rst) begin
			pos_q <= 3'h0;
			dir_q <= 1'b1;
			cnt_q <= 32'h0;
			speed_pulse <= 1'b0;
		end else if (ce) begin
			// direction only follows the input while rotation is slow
			if (!speed_fast)
				dir_q <= dir_s;
			if (brake) begin
				cnt_q <= 32'h0;
				speed_pulse <= 1'b0;
				pos_q <= pos_s;
			end else if (speed_pulse) begin
				// blanking: latch is closed until the pulse ends
				if (cnt_q <= 32'h1)
					speed_pulse <= 1'b0;
				cnt_q <= cnt_q - 32'h1;
			end else if (pos_change) begin
				pos_q <= pos_s;
				speed_pulse <= 1'b1;
				cnt_q <= PULSE_CYC;
			end
		end
	end
	// -------------------------------------------------------------------------
	// driver output stage
	// -------------------------------------------------------------------------
	wire [5:0] dec_w = bcd_decode(dir_q, pos_q);
	always @(posedge clk) begin
		if (rst) begin
			low_side <= `BCD_LOW_RST;
			high_side_n <= `BCD_HIGH_N_RST;
		end else if (ce) begin
			if (brake) begin
				low_side <= 3'h7 & {3{pwm_on}};
				high_side_n <= 3'h7;
			end else if (four_quadrant) begin
				low_side <= dec_w[5:3] & {3{pwm_on}};
				high_side_n <= ~(dec_w[2:0] & {3{pwm_on}});
			end else begin
				low_side <= dec_w[5:3] & {3{pwm_on}};
				high_side_n <= ~dec_w[2:0];
			end
		end
	end
endmodule // bcd_decoder

//--- test/bcd_hall.sv
// hall sensor model driving the three position lines
`timescale 1ns/1ps
module bcd_hall (
	input wire [2:0] pos,
	output wire a,
	output wire b,
	output wire c
);
	assign {a, b, c} = pos;
endmodule // bcd_hall

//--- test/bcd_decoder_chk.sv
// port assertions for the commutation decoder
`timescale 1ns/1ps
module bcd_decoder_chk #(parameter PULSE_CYC = 8) (
	input wire clk, rst, rotor_position_a, rotor_position_b, rotor_position_c,
	input wire four_quadrant, brake, pwm_on, speed_pulse,
	input wire [2:0] low_side, high_side_n
);
	wire [2:0] pos = {rotor_position_a, rotor_position_b, rotor_position_c};
	integer cnt_q;
	always @(posedge clk) cnt_q <= (rst || !speed_pulse) ? 0 : cnt_q + 1;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence off_code_s; ((pos == 3'h0 || pos == 3'h7) && !speed_pulse && !brake)[*4]; endsequence
	// reset is the trigger here, so the default reset disable must not apply
	rst_off_a: assert property (disable iff (1'b0) rst |=> low_side == 3'h0 && high_side_n == 3'h7 && !speed_pulse)
		else $error("reset drive");
	pulse_len_a: assert property ($fell(speed_pulse) && !$past(rst) && !$past(brake) |-> cnt_q == PULSE_CYC)
		else $error("pulse width");
	one_drive_a: assert property (!brake && !$past(brake) |-> $onehot0(low_side) && $onehot0(~high_side_n))
		else $error("drive count");
	brake_a: assert property (brake |=> high_side_n == 3'h7 && low_side == {3{$past(pwm_on)}} && !speed_pulse)
		else $error("brake drive");
	pwm_low_a: assert property (!pwm_on |=> low_side == 3'h0)
		else $error("low gate");
	pwm_high_a: assert property (!pwm_on && four_quadrant |=> high_side_n == 3'h7)
		else $error("high gate");
	pulse_start_a: assert property ($changed(pos) && !speed_pulse && !brake |-> ##[1:3] (speed_pulse || brake))
		else $error("no pulse");
	code_off_a: assert property (off_code_s |=> low_side == 3'h0 && high_side_n == 3'h7)
		else $error("illegal code");
endmodule // bcd_decoder_chk
bind bcd_decoder bcd_decoder_chk #(.PULSE_CYC(PULSE_CYC)) i_bcd_decoder_chk (.clk, .rst, .rotor_position_a,
	.rotor_position_b, .rotor_position_c, .four_quadrant, .brake, .pwm_on, .speed_pulse, .low_side, .high_side_n);

//--- test/bcd_decoder_tb_top.sv
// testbench for the commutation decoder
`timescale 1ns/1ps
module bcd_decoder_tb_top;
	localparam [23:0] LT = 24'h051910, HT = 24'h0a4288;
	reg clk = 0, rst = 1, dir = 1, fast = 0, fq = 0, brk = 0, pwm = 1;
	reg [2:0] pos = 3'h0;
	wire a, b, c, sp;
	wire [2:0] lo, hin;
	integer n_fail = 0, checked = 0, i;
	initial forever #5 clk = ~clk;
	bcd_hall i_bcd_hall (.pos(pos), .a(a), .b(b), .c(c));
	bcd_decoder #(.PULSE_CYC(8)) i_bcd_decoder (.clk(clk), .rst(rst), .ce(1'b1), .rotor_position_a(a),
		.rotor_position_b(b), .rotor_position_c(c), .direction(dir), .speed_fast(fast), .four_quadrant(fq),
		.brake(brk), .pwm_on(pwm), .speed_pulse(sp), .low_side(lo), .high_side_n(hin));
	task wt; repeat (16) @(negedge clk); endtask
	// l: low sides on, h: high sides on
	task chk(input [2:0] l, input [2:0] h);
		begin
			checked = checked + 1;
			if ({lo, hin} !== {l, ~h}) begin
				n_fail = n_fail + 1;
				$display("BAD %0t drive %b %b", $time, lo, hin);
			end
		end
	endtask
	// reverse direction swaps the low and high phase of each code
	task want;
		begin
			chk((dir ? LT[pos*3+:3] : HT[pos*3+:3]) & {3{pwm}}, (dir ? HT[pos*3+:3] : LT[pos*3+:3]) & {3{pwm | ~fq}});
		end
	endtask
	task t_decode;
		for (i = 0; i < 32; i = i + 1) begin
			{fq, dir, pos} = i[4:0];
			wt;
			want;
		end
	endtask
	task t_dir;
		begin
			dir = 1; pos = 3'h1; wt;
			fast = 1; dir = 0; wt;
			chk(3'h2, 3'h1);
			fast = 0; wt;
			want;
		end
	endtask
	task t_brake;
		begin
			brk = 1; wt;
			chk(3'h7, 3'h0);
			pwm = 0; wt;
			chk(3'h0, 3'h0);
			brk = 0; fq = 0; wt;
			want;
			fq = 1; wt;
			want;
		end
	endtask
	task t_blank;
		begin
			pwm = 1; pos = 3'h3; repeat (5) @(negedge clk);
			pos = 3'h2; repeat (4) @(negedge clk);
			chk(3'h1, 3'h4);
			checked = checked + 1;
			if (sp !== 1'b1) begin
				n_fail = n_fail + 1;
				$display("BAD %0t speed pulse not high", $time);
			end
			wt;
			want;
			checked = checked + 1;
			if (sp !== 1'b0) begin
				n_fail = n_fail + 1;
				$display("BAD %0t speed pulse not ended", $time);
			end
		end
	endtask
	task summarize;
		begin
			if (n_fail == 0 && checked > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst = 0;
		chk(3'h0, 3'h0);
		t_decode;
		t_dir;
		t_brake;
		t_blank;
		summarize;
	end
	initial begin
		#20000;
		n_fail = n_fail + 1;
		summarize;
	end
endmodule // bcd_decoder_tb_top
